// file: rtl/tmrcc_channel.v
// One timer channel: APB registers, input conditioning, counter and output flag
`timescale 1ns/1ps
`include "tmrcc_regs.vh"

// Summary of operation
// - Secondary source field picks one of four counter input pins.
// - Selected secondary input can capture the counter into the capture register.
// - Selected secondary input can set the counting direction.
// - With fault enable set, secondary input acts as a fault input.
// - Polarity invert setting inverts the selected secondary input.
// - One-shot bit: zero counts repeatedly, one stops after compare.
// - One-shot stops at compare one counting up, compare two counting down.
// - One-shot in mode 4: reinit at compare one, run to compare two, stop.
// - Length zero: keep counting past compare to binary roll over.
// - Length one: on match reload from reload value register.
// - Length one with mode 4: alternate compare one and two, reinit each.
// - Direction bit: zero counts up, one counts down.
// - Co-channel init bit lets other channels' compares reinitialise this one.
// - Output modes 000 active, 001 clear, 010 set, 011 toggle on compare.
// - Mode 100 toggles flag on alternating compare registers.
// - Mode 101 sets on compare, clears on secondary input edge.
// - Mode 111 gates the primary input level while active; divided bus clocks give inverted prescaler bit 0.
// - Edge counting uses rising edges, or falling edges with polarity invert.
// - Bus clock divide by 1 counts every cycle, polarity ignored.
// - Primary codes 1000 up select bus clock divided by powers of two.
module tmrcc_channel (
  // Clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Counter input pins
  input  wire [3:0]  cnt_pin,
  // Co-channel signals, same clock
  input  wire [3:0]  co_out,
  input  wire [3:0]  co_cmp,
  // Channel outputs
  output reg         output_flag,
  output reg         compare_event
);

  // Division tick from the free-running prescaler
  function tick_sel;
    input [3:0] src;
    input [6:0] p;
    begin
      case (src[2:0])
        3'h0:    tick_sel = 1'b1;
        3'h1:    tick_sel = &p[0:0];
        3'h2:    tick_sel = &p[1:0];
        3'h3:    tick_sel = &p[2:0];
        3'h4:    tick_sel = &p[3:0];
        3'h5:    tick_sel = &p[4:0];
        3'h6:    tick_sel = &p[5:0];
        default: tick_sel = &p[6:0];
      endcase
    end
  endfunction

  reg  [15:0] timer_channel_control_r;
  reg  [15:0] channel_status_control_r;
  reg  [15:0] compare_one_r;
  reg  [15:0] compare_two_r;
  reg  [15:0] compare_two_preload_r;
  reg  [15:0] reload_r;
  reg  [15:0] capture_r;
  reg  [15:0] counter_value_r;
  reg  [3:0]  pin_s1_r;
  reg  [3:0]  pin_s2_r;
  reg  [3:0]  pin_s3_r;
  reg  [3:0]  pin_f_r;
  reg  [6:0]  presc_r;
  reg         prim_prev_r;
  reg         sec_prev_r;
  reg         alt_r;
  reg         done_r;
  reg         output_flag_r;

  wire [2:0]  count_mode         = timer_channel_control_r[`TMRCC_CTRL_CM];
  wire [3:0]  prim_src           = timer_channel_control_r[`TMRCC_CTRL_PCS];
  wire [1:0]  sec_src            = timer_channel_control_r[`TMRCC_CTRL_SCS];
  wire        once_bit           = timer_channel_control_r[`TMRCC_CTRL_ONCE];
  wire        length_bit         = timer_channel_control_r[`TMRCC_CTRL_LEN];
  wire        dir_bit            = timer_channel_control_r[`TMRCC_CTRL_DIR];
  wire        cochannel_init_enable = timer_channel_control_r[`TMRCC_CTRL_COCHANNEL_INIT_ENABLE];
  wire [2:0]  output_flag_mode   = timer_channel_control_r[`TMRCC_CTRL_OM];
  wire        polarity_invert_bit = channel_status_control_r[`TMRCC_SCR_IPS];
  wire [1:0]  capture_mode       = channel_status_control_r[`TMRCC_SCR_CAPM];
  wire        fault_input_enable = channel_status_control_r[`TMRCC_SCR_FAULTEN];

  // APB access completes on the edge where pready is seen high
  wire        acc      = psel & penable & pready;
  wire        wr_acc   = acc & pwrite;
  wire        rd_setup = psel & penable & ~pready;

  // Secondary input after pin choice and polarity
  wire        sec_lvl  = pin_f_r[sec_src] ^ polarity_invert_bit;
  wire        sec_rise = sec_lvl & ~sec_prev_r;
  wire        sec_fall = ~sec_lvl & sec_prev_r;

  // Primary source level: pins are filtered, co-channel outputs share the clock
  wire        prim_raw = prim_src[2] ? co_out[prim_src[1:0]] : pin_f_r[prim_src[1:0]];
  wire        prim_div = prim_src[3];
  wire        prim_lvl = prim_raw ^ polarity_invert_bit;
  wire        prim_edge;
  wire        prim_any;
  wire        prim_tick;

  assign prim_edge = prim_div ? tick_sel(prim_src, presc_r) :
                     (prim_lvl & ~prim_prev_r);
  assign prim_any  = prim_div ? tick_sel(prim_src, presc_r) :
                     (prim_lvl ^ prim_prev_r);
  // Divide by 1 ticks every cycle regardless of polarity
  assign prim_tick = (prim_src == `TMRCC_PCS_DIV1) ? 1'b1 : prim_edge;

  wire active = (count_mode != `TMRCC_CM_STOP) & ~done_r;

  reg         step;
  reg         down;
  always @*
  begin
    step = 1'b0;
    down = dir_bit;
    case (count_mode)
      `TMRCC_CM_STOP:   step = 1'b0;
      `TMRCC_CM_BOTH:   step = prim_any;
      `TMRCC_CM_GATED:  step = prim_tick & sec_lvl;
      `TMRCC_CM_DIRSEC:
      begin
        step = prim_tick;
        down = dir_bit ^ sec_lvl;
      end
      default:          step = prim_tick;
    endcase
    step = step & active;
  end

  // Mode 4 alternates the compare target; otherwise direction picks it
  wire        alt_mode = (output_flag_mode == `TMRCC_OM_ALT);
  wire        use_two  = alt_mode ? alt_r : down;
  wire [15:0] target   = use_two ? compare_two_r : compare_one_r;
  wire        match    = step & (counter_value_r == target);
  wire        co_init  = cochannel_init_enable & (|co_cmp);
  wire        fault    = fault_input_enable & sec_lvl;

  wire        cap_hit  = (capture_mode == `TMRCC_CAPM_EDGE)  ? sec_rise :
                         (capture_mode == `TMRCC_CAPM_OTHER) ? sec_fall :
                         (capture_mode == `TMRCC_CAPM_BOTH)  ? (sec_rise | sec_fall) :
                         1'b0;

  // Input synchroniser and filter: a change counts once stages two and three agree
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_s1_r    <= 4'h0;
      pin_s2_r    <= 4'h0;
      pin_s3_r    <= 4'h0;
      pin_f_r     <= 4'h0;
      presc_r     <= 7'h00;
      prim_prev_r <= 1'b0;
      sec_prev_r  <= 1'b0;
    end
    else
    begin
      pin_s1_r    <= cnt_pin;
      pin_s2_r    <= pin_s1_r;
      pin_s3_r    <= pin_s2_r;
      pin_f_r     <= (pin_s2_r & pin_s3_r) | (pin_f_r & (pin_s2_r ^ pin_s3_r));
      presc_r     <= presc_r + 7'h01;
      prim_prev_r <= prim_lvl;
      sec_prev_r  <= sec_lvl;
    end
  end

  // APB handshake: one wait state, so read data and decode come from flops
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end
    else
    begin
      pready  <= rd_setup;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      if (rd_setup)
      begin
        case (paddr)
          `TMRCC_CMP1_ADDR:   prdata <= {16'h0000, compare_one_r};
          `TMRCC_CMP2_ADDR:   prdata <= {16'h0000, compare_two_r};
          `TMRCC_CAPT_ADDR:   prdata <= {16'h0000, capture_r};
          `TMRCC_LOAD_ADDR:   prdata <= {16'h0000, reload_r};
          `TMRCC_COUNTER_VALUE_ADDR:   prdata <= {16'h0000, counter_value_r};
          `TMRCC_CTRL_ADDR:   prdata <= {16'h0000, timer_channel_control_r};
          `TMRCC_SCR_ADDR:    prdata <= {16'h0000, channel_status_control_r[15:9], sec_lvl,
                                         channel_status_control_r[7:3], active,
                                         channel_status_control_r[1], output_flag_r};
          `TMRCC_COMPARE_TWO_PRELOAD_ADDR: prdata <= {16'h0000, compare_two_preload_r};
          default:            pslverr <= 1'b1;
        endcase
      end
    end
  end

  // Registers, counter and output flag
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timer_channel_control_r  <= `TMRCC_CTRL_RESET;
      channel_status_control_r <= `TMRCC_SCR_RESET;
      compare_one_r            <= `TMRCC_WORD_RESET;
      compare_two_r            <= `TMRCC_WORD_RESET;
      compare_two_preload_r    <= `TMRCC_WORD_RESET;
      reload_r                 <= `TMRCC_WORD_RESET;
      capture_r                <= `TMRCC_WORD_RESET;
      counter_value_r          <= `TMRCC_WORD_RESET;
      alt_r                    <= 1'b0;
      done_r                   <= 1'b0;
      output_flag_r                  <= 1'b0;
      output_flag              <= 1'b0;
      compare_event            <= 1'b0;
    end
    else
    begin
      compare_event <= match;

      // Counter path
      if (co_init)
      begin
        counter_value_r <= reload_r;
        alt_r           <= 1'b0;
      end
      else if (match)
      begin
        if (alt_mode)
          alt_r <= ~alt_r;
        if (once_bit)
        begin
          // Mode 4 one-shot reinitialises at compare one and stops at compare two
          if (alt_mode & ~alt_r)
            counter_value_r <= reload_r;
          else
            done_r <= 1'b1;
        end
        else if (length_bit)
          counter_value_r <= reload_r;
        else
          counter_value_r <= down ? counter_value_r - 16'h0001
                                  : counter_value_r + 16'h0001;
        if (alt_mode & ~alt_r)
          compare_two_r <= compare_two_preload_r;
      end
      else if (step)
        counter_value_r <= down ? counter_value_r - 16'h0001
                                : counter_value_r + 16'h0001;

      if (cap_hit)
        capture_r <= counter_value_r;

      // Output flag modes
      case (output_flag_mode)
        `TMRCC_OM_ACTIVE: output_flag_r <= active;
        `TMRCC_OM_CLR:    if (match) output_flag_r <= 1'b0;
        `TMRCC_OM_SET:    if (match) output_flag_r <= 1'b1;
        `TMRCC_OM_TOG:    if (match) output_flag_r <= ~output_flag_r;
        `TMRCC_OM_ALT:    if (match) output_flag_r <= ~output_flag_r;
        `TMRCC_OM_SETCLR:
        begin
          // Compare set wins over an input edge in the same cycle
          if (match)
            output_flag_r <= 1'b1;
          else if (sec_rise)
            output_flag_r <= 1'b0;
        end
        `TMRCC_OM_GATED:  output_flag_r <= active & ~prim_div & prim_lvl;
        default:          output_flag_r <= output_flag_r;
      endcase
      // Divided bus clock sources have no level to show, so the gated output is inverted prescaler bit 0
      if ((output_flag_mode == `TMRCC_OM_GATED) & prim_div)
        output_flag <= ~fault & active & ~presc_r[0];
      else
        output_flag <= ~fault & (output_flag_mode == `TMRCC_OM_GATED ?
                       active & prim_lvl : output_flag_r);

      // Software writes; a same-cycle compare keeps its flag set
      if (wr_acc)
      begin
        case (paddr)
          `TMRCC_CMP1_ADDR:   compare_one_r <= pwdata[15:0];
          `TMRCC_CMP2_ADDR:   compare_two_r <= pwdata[15:0];
          `TMRCC_LOAD_ADDR:   reload_r <= pwdata[15:0];
          `TMRCC_COUNTER_VALUE_ADDR:   counter_value_r <= pwdata[15:0];
          `TMRCC_COMPARE_TWO_PRELOAD_ADDR: compare_two_preload_r <= pwdata[15:0];
          `TMRCC_CTRL_ADDR:
          begin
            timer_channel_control_r <= pwdata[15:0];
            done_r                  <= 1'b0;
            alt_r                   <= 1'b0;
          end
          `TMRCC_SCR_ADDR:
          begin
            channel_status_control_r <= (pwdata[15:0] & `TMRCC_SCR_WMASK) |
              {channel_status_control_r[`TMRCC_SCR_TCF] & pwdata[`TMRCC_SCR_TCF] | match, 15'h0000};
          end
          // Read-only or unmapped offsets must not stall a counter step
          default:            ;
        endcase
      end
      if (match & ~(wr_acc & (paddr == `TMRCC_SCR_ADDR)))
        channel_status_control_r[`TMRCC_SCR_TCF] <= 1'b1;
    end
  end

endmodule // tmrcc_channel

// file: rtl/tmrcc_regs.vh
// Register map, field positions, codes and reset values of the timer channel
`ifndef TMRCC_REGS_VH
`define TMRCC_REGS_VH
`define TMRCC_CMP1_ADDR      8'h00
`define TMRCC_CMP2_ADDR      8'h04
`define TMRCC_CAPT_ADDR      8'h08
`define TMRCC_LOAD_ADDR      8'h0C
`define TMRCC_COUNTER_VALUE_ADDR      8'h10
`define TMRCC_CTRL_ADDR      8'h14
`define TMRCC_SCR_ADDR       8'h18
`define TMRCC_COMPARE_TWO_PRELOAD_ADDR    8'h1C
`define TMRCC_CTRL_CM        15:13
`define TMRCC_CTRL_PCS       12:9
`define TMRCC_CTRL_SCS       8:7
`define TMRCC_CTRL_ONCE      6
`define TMRCC_CTRL_LEN       5
`define TMRCC_CTRL_DIR       4
`define TMRCC_CTRL_COCHANNEL_INIT_ENABLE    3
`define TMRCC_CTRL_OM        2:0
`define TMRCC_SCR_TCF        15
`define TMRCC_SCR_IPS        9
`define TMRCC_SCR_INPUT      8
`define TMRCC_SCR_CAPM       7:6
`define TMRCC_SCR_ACTIVE     2
`define TMRCC_SCR_FAULTEN    1
`define TMRCC_SCR_OUTPUT_FLAG      0
`define TMRCC_SCR_WMASK      16'h02C2
`define TMRCC_CTRL_RESET     16'h0000
`define TMRCC_SCR_RESET      16'h0000
`define TMRCC_WORD_RESET     16'h0000
`define TMRCC_CM_STOP        3'h0
`define TMRCC_CM_EDGE        3'h1
`define TMRCC_CM_BOTH        3'h2
`define TMRCC_CM_GATED       3'h3
`define TMRCC_CM_DIRSEC      3'h6
`define TMRCC_OM_ACTIVE      3'h0
`define TMRCC_OM_CLR         3'h1
`define TMRCC_OM_SET         3'h2
`define TMRCC_OM_TOG         3'h3
`define TMRCC_OM_ALT         3'h4
`define TMRCC_OM_SETCLR      3'h5
`define TMRCC_OM_RSVD        3'h6
`define TMRCC_OM_GATED       3'h7
`define TMRCC_CAPM_OFF       2'h0
`define TMRCC_CAPM_EDGE      2'h1
`define TMRCC_CAPM_OTHER     2'h2
`define TMRCC_CAPM_BOTH      2'h3
`define TMRCC_PCS_DIV1       4'h8
`endif

// file: tb/tmrcc_channel_props.sv
// Port-level assertions for the timer channel, bound to its top module
`timescale 1ns/1ps
module tmrcc_channel_props (
  // Clock and reset
  input wire        pclk,
  input wire        presetn,
  // APB
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // Channel outputs
  input wire        output_flag,
  input wire        compare_event
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_one_wait_a: assert property (psel && $rose(penable) |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  ready_in_xfer_a: assert property (pready |-> psel && penable)
    else $error("pready outside a transfer");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data not zero while idle");
  rdata_upper_a: assert property (pready |-> prdata[31:16] == 16'h0000)
    else $error("upper read data bits not zero");
  // Unmapped reads must not leak stale data along with the error
  unmapped_err_a: assert property (pready && !pwrite && paddr > 8'h1F |-> pslverr && prdata == 32'h0)
    else $error("unmapped read not flagged");
  mapped_ok_a: assert property (pready && (pwrite || (paddr < 8'h20 && paddr[1:0] == 2'b00)) |-> !pslverr)
    else $error("error on a mapped access");
  reset_quiet_a: assert property ($rose(presetn) |-> !output_flag && !compare_event)
    else $error("outputs active right after reset");
endmodule // tmrcc_channel_props
bind tmrcc_channel tmrcc_channel_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .output_flag(output_flag), .compare_event(compare_event));

// file: tb/tmrcc_far_side.sv
// Far-side model: counter input pins and co-channel timers
`timescale 1ns/1ps
module tmrcc_far_side (
  // Clock
  input  wire       pclk,
  // Bench requests
  input  wire [3:0] pin_lvl,
  input  wire       cmp_req,
  // Toward the channel
  output reg  [3:0] cnt_pin,
  output reg  [3:0] co_out,
  output reg  [3:0] co_cmp
);
  initial
  begin
    cnt_pin = 4'h0;
    co_out  = 4'h0;
    co_cmp  = 4'h0;
  end
  // Co-channel flags free-run so a wrong primary pick shows up as stray ticks
  always @(posedge pclk)
  begin
    cnt_pin <= pin_lvl;
    co_out  <= co_out + 4'h1;
    co_cmp  <= {3'h0, cmp_req};
  end
endmodule // tmrcc_far_side

// file: tb/timer_channel_count_control_tb.sv
// Self-checking bench for the timer channel control logic
`timescale 1ns/1ps
`include "tmrcc_regs.vh"
module timer_channel_count_control_tb;
  localparam [7:0] C1 = `TMRCC_CMP1_ADDR, C2 = `TMRCC_CMP2_ADDR, LD = `TMRCC_LOAD_ADDR;
  localparam [7:0] CN = `TMRCC_COUNTER_VALUE_ADDR, CT = `TMRCC_CTRL_ADDR, SC = `TMRCC_SCR_ADDR, PL = `TMRCC_COMPARE_TWO_PRELOAD_ADDR;
  reg         pclk    = 1'b0;
  reg         presetn = 1'b0;
  reg         psel    = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite  = 1'b0;
  reg  [7:0]  paddr   = 8'h00;
  reg  [31:0] pwdata  = 32'h0;
  reg  [3:0]  pin_lvl = 4'h0;
  reg         cmp_req = 1'b0;
  wire [31:0] prdata;
  wire        pready, pslverr, output_flag, compare_event;
  wire [3:0]  cnt_pin, co_out, co_cmp;
  reg  [31:0] rd;
  reg         err, f;
  integer     error_cnt = 0;
  integer     compares = 0;
  integer     ev_cnt = 0;
  integer     i, j;
  always #12.5 pclk = ~pclk;
  always @(posedge pclk)
    if (compare_event === 1'b1)
      ev_cnt <= ev_cnt + 1;
  tmrcc_channel DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cnt_pin(cnt_pin),
    .co_out(co_out), .co_cmp(co_cmp), .output_flag(output_flag), .compare_event(compare_event));
  tmrcc_far_side u_far (.pclk(pclk), .pin_lvl(pin_lvl), .cmp_req(cmp_req), .cnt_pin(cnt_pin),
    .co_out(co_out), .co_cmp(co_cmp));
  task complete_run;
    begin
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task check(input [31:0] got, input [31:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp)
      begin
        error_cnt = error_cnt + 1;
        $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task wt(input integer c);
    begin
      repeat (c) @(posedge pclk);
    end
  endtask
  // Request held until pready is seen at a rising edge; the wait is bounded
  task apb(input w, input [7:0] a, input [31:0] d);
    integer k;
    begin
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && k < 20)
      begin
        @(posedge pclk);
        k = k + 1;
      end
      if (k == 20)
      begin
        error_cnt = error_cnt + 1;
        complete_run;
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task wr(input [7:0] a, input [15:0] d);
    begin
      apb(1'b1, a, {16'h0000, d});
    end
  endtask
  task rdc(input [7:0] a, input [31:0] exp);
    begin
      apb(1'b0, a, 32'h0);
      check(rd, exp);
    end
  endtask
  initial
  begin
    wt(4);
    presetn <= 1'b1;
    rdc(CT, 32'h0);
    rdc(SC, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    check(err, 1'b1);
    wr(C1, 16'h0005);
    wr(CT, 16'h3242);              // edge count uses divide by 2, one-shot, mode 010 sets on compare
    wt(40);
    rdc(CN, 32'h5);
    check(output_flag, 1'b1);
    wr(SC, 16'h0002);
    pin_lvl <= 4'h1;
    wt(8);
    check(output_flag, 1'b0);
    pin_lvl <= 4'h0;
    wt(8);
    check(output_flag, 1'b1);
    wr(SC, 16'h0000);
    wr(CN, 16'h0000);
    wr(C2, 16'hFFFA);
    wr(CT, 16'h3251);
    wt(40);
    rdc(CN, 32'hFFFA);
    check(output_flag, 1'b0);
    wr(CN, 16'h0000);
    wr(CT, 16'h3245);
    wt(40);
    check(output_flag, 1'b1);
    pin_lvl <= 4'h1;
    wt(8);
    check(output_flag, 1'b0);
    pin_lvl <= 4'h0;
    wr(LD, 16'h0010);
    wr(C1, 16'h0014);
    wr(C2, 16'h0018);
    wr(PL, 16'h0018);
    // Toggle, then alternating compares; flag parity must follow the match count
    for (i = 3; i < 5; i = i + 1)
    begin
      wr(CN, 16'h0010);
      f = output_flag;
      j = ev_cnt;
      wr(CT, {13'h0644, i[2:0]});
      wt(120);
      wr(CT, {13'h0000, i[2:0]});
      wt(4);
      apb(1'b0, CN, 32'h0);
      check(rd >= 32'h10 && rd <= (i == 3 ? 32'h14 : 32'h18), 1'b1);
      check(ev_cnt - j > 4, 1'b1);
      check(output_flag, f ^ ((ev_cnt - j) % 2));
    end
    wr(LD, 16'h0100);
    for (j = 0; j < 2; j = j + 1)
    begin
      wr(CN, 16'h0000);
      wr(CT, {12'h320, j[0], 3'h0});
      wt(6);
      cmp_req <= 1'b1;
      wt(1);
      cmp_req <= 1'b0;
      check(output_flag, 1'b1);
      wt(2);
      wr(CT, 16'h0000);
      apb(1'b0, CN, 32'h0);
      check(rd[15:8], j);
      check(output_flag, 1'b0);
    end
    for (i = 0; i < 8; i = i + 1)
    begin
      wr(SC, {6'h00, i[2], 9'h000});
      wr(CT, {7'h00, i[1:0], 7'h00});
      pin_lvl <= 4'h1 << i[1:0];
      wt(8);
      apb(1'b0, SC, 32'h0);
      check(rd[8], {31'h0, ~i[2]});
    end
    complete_run;
  end
endmodule // timer_channel_count_control_tb
